// >>> rmcs_mode_seq.v
// Operating-mode command sequencer with APB registers and radio control outputs.
//
// Function
// - Reset comes up in RC standby mode.
// - Standby opcode selects RC or crystal.
// - Standby idles awaiting commands.
// - Synth command locks PLL to carrier.
// - RC standby to TX/RX passes synth.
// - Transmit opcode carries 24-bit timeout.
// - Oscillator, PLL, amplifier, ramp, then send.
// - After last bit: done, ramp down, standby.
// - Nonzero timeout expiry raises timeout, standby.
// - Timer steps are 15.625 us each.
// - Zero transmit timeout disables the timer.
// - Receive opcode carries 24-bit timeout.
// - Zero receive timeout means single reception.
// - All-ones timeout means continuous reception.
// - Other values arm timer; first end wins.
// - Qualifying detection halts the armed timer.
// - Halt select chooses preamble or sync.
// - Preamble halt stays in receive until packet.
`timescale 1ns/1ps
`include "rmcs_defines.vh"
module rmcs_mode_seq #(
	parameter STEP_CYC = `RMCS_STEP_CYC
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire tx_last_bit,
	input wire rx_packet_done,
	input wire preamble_det,
	input wire sync_det,
	output reg crystal_en,
	output reg pll_en,
	output reg pa_en,
	output reg pa_ramp_up,
	output reg tx_send,
	output reg rx_en,
	output reg busy,
	output reg irq
);
	localparam ST_RC = 4'h0;
	localparam ST_XTAL = 4'h1;
	localparam ST_OSC = 4'h2;
	localparam ST_PLL = 4'h3;
	localparam ST_SYNTH = 4'h4;
	localparam ST_RAMP_UP = 4'h5;
	localparam ST_TX = 4'h6;
	localparam ST_RAMP_DN = 4'h7;
	localparam ST_RX = 4'h8;

	reg [3:0] state_reg;
	reg [3:0] state_next;
	reg [15:0] wait_reg;
	reg [7:0] opcode_reg;
	reg [23:0] arg_reg;
	reg go_reg;
	reg target_tx_reg;
	reg target_rx_reg;
	reg [23:0] tmo_reg;
	reg halt_pre_reg;
	reg timer_halted_reg;
	reg [15:0] ramp_reg;
	reg [`RMCS_IRQ_BITS-1:0] status_reg;
	reg [`RMCS_IRQ_BITS-1:0] irq_en_reg;
	reg [`RMCS_IRQ_BITS-1:0] set_vec;
	reg [`RMCS_IRQ_BITS-1:0] clr_vec;
	reg timer_start;
	reg timer_stop;
	reg [4:0] ev_s1_reg;
	reg [4:0] ev_s2_reg;
	reg [4:0] ev_d_reg;
	wire [4:0] ev_rise;
	wire timer_expired;
	wire timer_running;
	wire wr_acc;
	wire rd_acc;
	wire cont_mode;
	wire halt_hit;

	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && !penable && !pwrite;
	assign ev_rise = ev_s2_reg & ~ev_d_reg;
	assign cont_mode = (tmo_reg == `RMCS_TMO_CONT);
	// Detection qualifies on preamble only when the halt select is set.
	assign halt_hit = halt_pre_reg ? ev_rise[`RMCS_EV_PREAMBLE] : ev_rise[`RMCS_EV_SYNC];

	// Radio-side event pins come from another domain.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_s1_reg <= 5'h00;
			ev_s2_reg <= 5'h00;
			ev_d_reg <= 5'h00;
		end else begin
			ev_s1_reg <= {sync_det, preamble_det, 1'b0, rx_packet_done, tx_last_bit};
			ev_s2_reg <= ev_s1_reg;
			ev_d_reg <= ev_s2_reg;
		end
	end

	rmcs_step_timer #(
		.STEP_CYC(STEP_CYC)
	) u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.start(timer_start),
		.stop(timer_stop),
		.load_value(tmo_reg),
		.expired(timer_expired),
		.running(timer_running)
	);

	// APB writes: the command register launches the decoded opcode.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opcode_reg <= 8'h00;
			arg_reg <= 24'h000000;
			go_reg <= 1'b0;
			irq_en_reg <= {`RMCS_IRQ_BITS{1'b0}};
			ramp_reg <= `RMCS_RAMP_RST;
		end else begin
			go_reg <= 1'b0;
			if (wr_acc) begin
				case (paddr)
				`RMCS_ADDR_ARG: arg_reg <= pwdata[23:0];
				`RMCS_ADDR_CMD: begin
					opcode_reg <= pwdata[7:0];
					go_reg <= 1'b1;
				end
				`RMCS_ADDR_IRQ_EN: irq_en_reg <= pwdata[`RMCS_IRQ_BITS-1:0];
				`RMCS_ADDR_RAMP: ramp_reg <= pwdata[15:0];
				default: ;
				endcase
			end
		end
	end

	always @* begin
		clr_vec = {`RMCS_IRQ_BITS{1'b0}};
		if (wr_acc && paddr == `RMCS_ADDR_IRQ_CLR)
			clr_vec = pwdata[`RMCS_IRQ_BITS-1:0];
	end

	// Sequencer next state and event generation.
	always @* begin
		state_next = state_reg;
		set_vec = {`RMCS_IRQ_BITS{1'b0}};
		timer_start = 1'b0;
		timer_stop = 1'b0;
		case (state_reg)
		ST_RC, ST_XTAL, ST_SYNTH: begin
			if (state_reg == ST_SYNTH && (target_tx_reg || target_rx_reg)) begin
				state_next = target_tx_reg ? ST_RAMP_UP : ST_RX;
				timer_start = target_rx_reg && tmo_reg != `RMCS_TMO_OFF && !cont_mode;
			end
		end
		ST_OSC: if (wait_reg == 16'h0000) state_next = ST_PLL;
		ST_PLL: if (wait_reg == 16'h0000) state_next = ST_SYNTH;
		ST_RAMP_UP: begin
			if (wait_reg == 16'h0000) begin
				state_next = ST_TX;
				timer_start = (tmo_reg != `RMCS_TMO_OFF);
			end
		end
		ST_TX: begin
			if (ev_rise[`RMCS_EV_TX_DONE]) begin
				set_vec[`RMCS_IRQ_TX_DONE] = 1'b1;
				timer_stop = 1'b1;
				state_next = ST_RAMP_DN;
			end else if (timer_expired) begin
				set_vec[`RMCS_IRQ_TIMEOUT] = 1'b1;
				state_next = ST_RAMP_DN;
			end
		end
		ST_RAMP_DN: if (wait_reg == 16'h0000) state_next = ST_RC;
		ST_RX: begin
			if (timer_running && halt_hit)
				timer_stop = 1'b1;
			if (ev_rise[`RMCS_EV_RX_DONE]) begin
				set_vec[`RMCS_IRQ_RX_DONE] = 1'b1;
				timer_stop = 1'b1;
				if (!cont_mode)
					state_next = ST_RC;
			end else if (timer_expired && !timer_halted_reg) begin
				set_vec[`RMCS_IRQ_TIMEOUT] = 1'b1;
				state_next = ST_RC;
			end
		end
		default: state_next = ST_RC;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_RC;
			wait_reg <= 16'h0000;
			target_tx_reg <= 1'b0;
			target_rx_reg <= 1'b0;
			tmo_reg <= `RMCS_TMO_OFF;
			halt_pre_reg <= 1'b0;
			timer_halted_reg <= 1'b0;
			status_reg <= {`RMCS_IRQ_BITS{1'b0}};
		end else begin
			status_reg <= (status_reg & ~clr_vec) | set_vec;
			if (wait_reg != 16'h0000)
				wait_reg <= wait_reg - 16'h0001;
			if (timer_stop)
				timer_halted_reg <= 1'b1;
			if (timer_start)
				timer_halted_reg <= 1'b0;
			state_reg <= state_next;
			if (state_next != state_reg) begin
				case (state_next)
				ST_PLL: wait_reg <= `RMCS_PLL_CYC;
				ST_RAMP_UP, ST_RAMP_DN: wait_reg <= ramp_reg;
				ST_SYNTH: ;
				default: ;
				endcase
				if (state_next == ST_RAMP_UP || state_next == ST_RX) begin
					target_tx_reg <= 1'b0;
					target_rx_reg <= 1'b0;
				end
			end
			// Commands are taken only while not busy: in a standby or synth state, or in continuous receive.
			if (go_reg && !busy) begin
				case (opcode_reg)
				`RMCS_OP_STANDBY: begin
					state_reg <= (arg_reg[7:0] == `RMCS_SEL_XTAL) ? ST_XTAL : ST_RC;
					target_tx_reg <= 1'b0;
					target_rx_reg <= 1'b0;
				end
				`RMCS_OP_HALT_PRE: halt_pre_reg <= arg_reg[0];
				`RMCS_OP_SYNTH, `RMCS_OP_TX, `RMCS_OP_RX: begin
					tmo_reg <= arg_reg;
					target_tx_reg <= (opcode_reg == `RMCS_OP_TX);
					target_rx_reg <= (opcode_reg == `RMCS_OP_RX);
					if (state_reg == ST_RC) begin
						state_reg <= ST_OSC;
						wait_reg <= `RMCS_OSC_CYC;
					end else if (state_reg == ST_XTAL) begin
						state_reg <= ST_PLL;
						wait_reg <= `RMCS_PLL_CYC;
					end else if (state_reg == ST_RX) begin
						// Leaving continuous receive: the PLL is still locked.
						state_reg <= ST_SYNTH;
					end
				end
				default: ;
				endcase
			end
		end
	end

	// Radio control outputs follow the current state, one cycle behind it; busy and irq also take in commands and status.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crystal_en <= 1'b0;
			pll_en <= 1'b0;
			pa_en <= 1'b0;
			pa_ramp_up <= 1'b0;
			tx_send <= 1'b0;
			rx_en <= 1'b0;
			busy <= 1'b0;
			irq <= 1'b0;
		end else begin
			crystal_en <= state_reg != ST_RC;
			pll_en <= state_reg == ST_SYNTH || state_reg == ST_RAMP_UP || state_reg == ST_TX ||
				state_reg == ST_RAMP_DN || state_reg == ST_RX;
			pa_en <= state_reg == ST_RAMP_UP || state_reg == ST_TX || state_reg == ST_RAMP_DN;
			pa_ramp_up <= state_reg == ST_RAMP_UP || state_reg == ST_TX;
			tx_send <= state_reg == ST_TX;
			rx_en <= state_reg == ST_RX;
			// Continuous receive stays open to new mode commands.
			busy <= go_reg || (state_reg != ST_RC && state_reg != ST_XTAL && state_reg != ST_SYNTH &&
				!(state_reg == ST_RX && cont_mode)) || target_tx_reg || target_rx_reg;
			irq <= |(status_reg & irq_en_reg);
		end
	end

	// APB read data is latched in setup; access completes with no wait states.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b1;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				case (paddr)
				`RMCS_ADDR_CMD, `RMCS_ADDR_ARG, `RMCS_ADDR_IRQ_CLR, `RMCS_ADDR_IRQ_EN,
				`RMCS_ADDR_RAMP, `RMCS_ADDR_MODE, `RMCS_ADDR_STATUS: pslverr <= 1'b0;
				default: pslverr <= 1'b1;
				endcase
			end
			if (rd_acc) begin
				case (paddr)
				`RMCS_ADDR_ARG: prdata <= {8'h00, arg_reg};
				`RMCS_ADDR_MODE: prdata <= {22'h000000, halt_pre_reg, timer_running, busy,
					1'b0, state_reg, opcode_reg[0], 1'b0};
				`RMCS_ADDR_STATUS: prdata <= {29'h00000000, status_reg};
				`RMCS_ADDR_IRQ_EN: prdata <= {29'h00000000, irq_en_reg};
				`RMCS_ADDR_RAMP: prdata <= {16'h0000, ramp_reg};
				default: prdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule

// >>> rmcs_defines.vh
// Opcodes, selector values, bus offsets, field positions and timing counts of the mode sequencer.
`ifndef RMCS_DEFINES_VH
`define RMCS_DEFINES_VH
`define RMCS_OP_STANDBY 8'h80
`define RMCS_OP_SYNTH 8'hC1
`define RMCS_OP_RX 8'h82
`define RMCS_OP_TX 8'h83
`define RMCS_OP_HALT_PRE 8'h9F
`define RMCS_SEL_RC 8'h00
`define RMCS_SEL_XTAL 8'h01
`define RMCS_TMO_OFF 24'h000000
`define RMCS_TMO_CONT 24'hFFFFFF
`define RMCS_ADDR_CMD 12'h000
`define RMCS_ADDR_ARG 12'h004
`define RMCS_ADDR_MODE 12'h008
`define RMCS_ADDR_EVENT 12'h00C
`define RMCS_ADDR_STATUS 12'h010
`define RMCS_ADDR_IRQ_EN 12'h014
`define RMCS_ADDR_IRQ_CLR 12'h018
`define RMCS_ADDR_RAMP 12'h01C
`define RMCS_EV_TX_DONE 0
`define RMCS_EV_RX_DONE 1
`define RMCS_EV_TIMEOUT 2
`define RMCS_EV_PREAMBLE 3
`define RMCS_EV_SYNC 4
`define RMCS_IRQ_TX_DONE 0
`define RMCS_IRQ_RX_DONE 1
`define RMCS_IRQ_TIMEOUT 2
`define RMCS_IRQ_BITS 3
`define RMCS_STEP_NS 15625
`define RMCS_CLK_NS 40
`define RMCS_STEP_CYC ((`RMCS_STEP_NS + `RMCS_CLK_NS - 1) / `RMCS_CLK_NS)
`define RMCS_OSC_CYC 16'd64
`define RMCS_PLL_CYC 16'd64
`define RMCS_RAMP_RST 16'h0020
`endif

// >>> rmcs_step_timer.v
// Timeout timer: a step divider and a 24-bit step counter with end-of-count pulse.
`timescale 1ns/1ps
`include "rmcs_defines.vh"
module rmcs_step_timer #(
	parameter STEP_CYC = `RMCS_STEP_CYC
) (
	input wire pclk,
	input wire presetn,
	input wire start,
	input wire stop,
	input wire [23:0] load_value,
	output reg expired,
	output wire running
);
	reg [15:0] div_reg;
	reg [23:0] count_reg;
	reg run_reg;
	wire step_tick;
	assign step_tick = run_reg && (div_reg == STEP_CYC[15:0] - 16'h0001);
	assign running = run_reg;
	// Step size sets the timeout resolution.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= 16'h0000;
			count_reg <= 24'h000000;
			run_reg <= 1'b0;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (start) begin
				div_reg <= 16'h0000;
				count_reg <= load_value;
				run_reg <= 1'b1;
			end else if (stop) begin
				run_reg <= 1'b0;
			end else if (run_reg) begin
				if (step_tick) begin
					div_reg <= 16'h0000;
					if (count_reg == 24'h000001) begin
						run_reg <= 1'b0;
						expired <= 1'b1;
					end
					count_reg <= count_reg - 24'h000001;
				end else begin
					div_reg <= div_reg + 16'h0001;
				end
			end
		end
	end
endmodule

// >>> rmcs_mode_seq_chk.sv
// Port checker of the mode sequencer.
`timescale 1ns/1ps
module rmcs_mode_seq_chk #(
	parameter STEP_CYC = 391
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire tx_last_bit,
	input wire rx_packet_done,
	input wire preamble_det,
	input wire sync_det,
	input wire crystal_en,
	input wire pll_en,
	input wire pa_en,
	input wire pa_ramp_up,
	input wire tx_send,
	input wire rx_en,
	input wire busy,
	input wire irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_reset_rc_idle: assert property ($rose(presetn) |-> !crystal_en && !pll_en && !pa_en)
		else $error("not idle after reset");
	chk_pready_up: assert property (pready) else $error("pready low");
	chk_slverr_unmapped: assert property (psel && penable && paddr > 12'h01C |-> pslverr)
		else $error("no error on unmapped access");
	chk_rx_needs_pll: assert property (rx_en |-> pll_en) else $error("rx without pll");
	chk_tx_rx_apart: assert property (!(tx_send && rx_en)) else $error("tx and rx together");
	chk_busy_on_tx: assert property (psel && penable && pwrite && paddr == 12'h000
		&& pwdata[7:0] == 8'h83 && !busy |-> ##[1:3] busy) else $error("busy missing");
	chk_send_needs_pa: assert property (tx_send |-> pa_en && pll_en) else $error("send w/o pa");
	chk_ramp_first: assert property ($rose(tx_send) |-> $past(pa_ramp_up))
		else $error("send before ramp");
	chk_last_bit_ends: assert property ($rose(tx_last_bit) && tx_send |-> ##[1:6] !tx_send)
		else $error("tx not ended");
	chk_pa_off_after: assert property ($fell(tx_send) |-> ##[1:60] !pa_en)
		else $error("pa left on");
endmodule

// >>> rmcs_radio_model.sv
// Radio front end model answering transmit and receive activity.
`timescale 1ns/1ps
module rmcs_radio_model (
	input wire pclk,
	input wire tx_send,
	input wire rx_en,
	input wire [1:0] mode,
	output logic tx_last_bit,
	output logic rx_packet_done,
	output logic preamble_det,
	output logic sync_det
);
	int t = 0;
	// Mode 0 answers, mode 1 stays silent, mode 2 shows a preamble and a very late packet.
	always @(posedge pclk) begin
		t <= (tx_send || rx_en) ? t + 1 : 0;
	end
	assign tx_last_bit = tx_send && mode != 2'd1 && t >= 20 && t < 22;
	assign sync_det = rx_en && mode == 2'd0 && t >= 20 && t < 22;
	assign preamble_det = rx_en && mode == 2'd2 && t >= 20 && t < 22;
	assign rx_packet_done = rx_en && ((mode == 2'd0 && t >= 30 && t < 32)
		|| (mode == 2'd2 && t >= 600 && t < 602));
endmodule

// >>> rmcs_mode_seq_bench.sv
// Self-checking bench of the mode sequencer.
`timescale 1ns/1ps
`include "rmcs_defines.vh"
`define CK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin failures++; \
	$display("MISMATCH %s exp %h got %h", n, e, a); end end
module rmcs_mode_seq_bench;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [1:0] mode = 0;
	wire [31:0] prdata;
	wire pready, pslverr, tx_last_bit, rx_packet_done, preamble_det, sync_det;
	wire crystal_en, pll_en, pa_en, pa_ramp_up, tx_send, rx_en, busy, irq;
	logic [31:0] q[$];
	logic [31:0] e;
	logic [31:0] rmp;
	int failures = 0;
	int samples_checked = 0;
	int cyc = 0;
	rmcs_mode_seq #(.STEP_CYC(4)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .tx_last_bit, .rx_packet_done, .preamble_det,
		.sync_det, .crystal_en, .pll_en, .pa_en, .pa_ramp_up, .tx_send, .rx_en, .busy, .irq);
	rmcs_radio_model rad (.pclk, .tx_send, .rx_en, .mode, .tx_last_bit, .rx_packet_done,
		.preamble_det, .sync_det);
	initial forever #20 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			failures++;
			results();
		end
	end
	always @(posedge pclk) if (psel && penable && pready && !pwrite) begin
		e = q.pop_front();
		`CK("prdata", e, prdata)
	end
	task results;
		$display("failures=%0d samples_checked=%0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 0;
		penable <= 0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] x);
		q.push_back(x);
		apb(0, a, 0);
	endtask
	task cmd(input logic [7:0] op, input logic [31:0] arg);
		while (busy !== 1'b0) @(posedge pclk);
		apb(1, `RMCS_ADDR_ARG, arg);
		apb(1, `RMCS_ADDR_CMD, {24'h0, op});
		repeat (3) @(posedge pclk);
	endtask
	task ev(input logic [7:0] op, input logic [31:0] tmo, input logic [1:0] md,
		input logic [31:0] x);
		mode <= md;
		cmd(op, tmo);
		while (irq !== 1'b1) @(posedge pclk);
		rd(`RMCS_ADDR_STATUS, x);
		apb(1, `RMCS_ADDR_IRQ_CLR, 7);
		rd(`RMCS_ADDR_STATUS, 0);
	endtask
	initial begin
		rmp = $urandom(32'h1fa7);
		repeat (20) @(posedge pclk);
		presetn <= 1;
		rd(`RMCS_ADDR_RAMP, 32'h20);
		rd(`RMCS_ADDR_STATUS, 0);
		rd(12'h020, 0);
		`CK("xtal", 1'b0, crystal_en)
		rmp = $urandom_range(40, 1);
		apb(1, `RMCS_ADDR_RAMP, rmp);
		rd(`RMCS_ADDR_RAMP, rmp);
		apb(1, `RMCS_ADDR_IRQ_EN, 4);
		cmd(8'h83, 0);
		while (tx_send !== 1'b1) @(posedge pclk);
		while (pa_en !== 1'b0) @(posedge pclk);
		@(negedge pclk);
		`CK("irq", 1'b0, irq)
		rd(`RMCS_ADDR_STATUS, 1);
		apb(1, `RMCS_ADDR_IRQ_EN, 7);
		@(posedge pclk);
		@(negedge pclk);
		`CK("irq", 1'b1, irq)
		apb(1, `RMCS_ADDR_IRQ_CLR, 7);
		ev(8'h83, 2, 1, 4);
		ev(8'h82, 0, 0, 2);
		ev(8'h82, $urandom_range(8, 1), 1, 4);
		ev(8'h82, 100, 0, 2);
		ev(8'h82, 32'hFFFFFF, 0, 2);
		`CK("rx_en", 1'b1, rx_en)
		cmd(8'h80, 0);
		@(negedge pclk);
		`CK("rx_en", 1'b0, rx_en)
		cmd(8'h80, 1);
		@(negedge pclk);
		`CK("xtal", 1'b1, crystal_en)
		cmd(8'h80, 0);
		@(negedge pclk);
		`CK("xtal", 1'b0, crystal_en)
		cmd(8'h9F, 1);
		ev(8'h82, 100, 2, 2);
		results();
	end
endmodule
bind rmcs_mode_seq rmcs_mode_seq_chk #(.STEP_CYC(STEP_CYC)) chk (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_last_bit,
	.rx_packet_done, .preamble_det, .sync_det, .crystal_en, .pll_en, .pa_en, .pa_ramp_up,
	.tx_send, .rx_en, .busy, .irq);
